// ### hw/ifb_pkg.sv
package ifb_pkg;

    // System clock rate (CPU clock)
    localparam int          CLK_SYS_MHZ    = 250;
    localparam int          CLK_SYS_NS     = 1000 / CLK_SYS_MHZ;

    // Reset-time clock selection codes
    localparam logic [1:0]  SEL_EXT        = 2'h0;
    localparam logic [1:0]  SEL_CPU4       = 2'h1;
    localparam logic [1:0]  SEL_CPU6       = 2'h2;
    localparam logic [1:0]  SEL_RSVD       = 2'h3;

    // CPU clock division ratios
    localparam logic [2:0]  CPU_DIV4       = 3'h4;
    localparam logic [2:0]  CPU_DIV6       = 3'h6;

    // Second output clock division codes
    localparam logic [1:0]  DIV_BY1        = 2'h0;
    localparam logic [1:0]  DIV_BY2        = 2'h1;
    localparam logic [1:0]  DIV_BY4        = 2'h2;

    // Memory type per chip-enable space
    localparam logic [1:0]  MEM_ASYNC      = 2'h0;
    localparam logic [1:0]  MEM_SDRAM      = 2'h1;
    localparam logic [1:0]  MEM_SYNC       = 2'h2;

    // Register byte offsets
    localparam logic [7:0]  REG_CTRL       = 8'h00;
    localparam logic [7:0]  REG_SPACE      = 8'h04;
    localparam logic [7:0]  REG_TIMING     = 8'h08;
    localparam logic [7:0]  REG_STATUS     = 8'h0C;

    // Field positions
    localparam int          CTRL_DIV_LSB   = 0;
    localparam int          SPACE_FLD_W    = 4;
    localparam int          SPACE_TYPE_LSB = 0;
    localparam int          SPACE_RES_BIT  = 2;
    localparam int          TIM_STB_LSB    = 0;
    localparam int          STAT_SEL_LSB   = 0;
    localparam int          STAT_STRAP_BIT = 2;
    localparam int          STAT_HOLD_BIT  = 3;
    localparam int          STAT_BUSY_BIT  = 4;
    localparam int          STAT_ERR_BIT   = 5;

    // Reset values
    localparam logic [1:0]  CTRL_RST       = 2'h0;
    localparam logic [15:0] SPACE_RST      = 16'h0000;
    localparam logic [3:0]  STROBE_RST     = 4'h2;

    // Word-address region that holds the four spaces
    localparam logic [3:0]  SPACE_REGION   = 4'h8;

    // Cycles after reset before the straps are taken
    localparam logic [1:0]  STRAP_SETTLE   = 2'h3;

    typedef enum logic [5:0]
    {
        ST_IDLE   = 6'h01,
        ST_SETUP  = 6'h02,
        ST_STROBE = 6'h04,
        ST_WAIT   = 6'h08,
        ST_FINISH = 6'h10,
        ST_HOLD   = 6'h20
    } state_e;

endpackage

// ### hw/cpu_clk_div.sv
module cpu_clk_div
    import ifb_pkg::*;
#(
    parameter int CNT_W = 3
)
(
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic [CNT_W-1:0] div_n,
    output logic                  lvl
);

    generate
        if (CNT_W < 3)
        begin : g_chk
            $error("cpu_clk_div needs at least three counter bits");
        end
    endgenerate

    typedef struct packed
    {
        logic [CNT_W-1:0] cnt;
        logic             lvl;
    } div_s;

    div_s s;
    div_s next_s;

    // Wrap the counter at div_n, high for the first half of the period
    always_comb
    begin
        next_s = s;
        if (s.cnt >= CNT_W'(div_n - 1'b1))
        begin
            next_s.cnt = '0;
        end
        else
        begin
            next_s.cnt = CNT_W'(s.cnt + 1'b1);
        end
        next_s.lvl = (next_s.cnt < (div_n >> 1));
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign lvl = s.lvl;

endmodule

// ### hw/ifb_pin_ctrl.sv
// Strobed register access and the register offsets were chosen for this implementation.
module ifb_pin_ctrl
    import ifb_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        req_valid,
    input  wire logic        req_write,
    input  wire logic [31:0] req_addr,
    input  wire logic [1:0]  req_be,
    input  wire logic        req_pdt,
    output logic             req_busy,
    output logic             req_done,
    output logic             req_err,
    input  wire logic        ifb_ext_clk_in,
    input  wire logic [1:0]  ifb_clk_sel_straps,
    input  wire logic        async_ready_in,
    input  wire logic        hold_req_in_n,
    output logic             ifb_clk_out_full,
    output logic             ifb_clk_out_div,
    output logic      [3:0]  chip_en_n,
    output logic             shared_rd_strobe_n,
    output logic             shared_oe_ras_pin_n,
    output logic             shared_write_en_pin_n,
    output logic             fifo_space3_oe_n,
    output logic      [1:0]  byte_write_en_n,
    output logic             periph_direct_xfer_n,
    output logic             hold_ack_out_n,
    output logic             bus_req_out,
    output logic             pin_drive_en
);

    typedef struct packed
    {
        state_e      st;
        logic [2:0]  ext_sync;
        logic [1:0]  strap_a;
        logic [1:0]  strap_b;
        logic [1:0]  strap_c;
        logic [2:0]  rdy_sync;
        logic [2:0]  hold_sync;
        logic        ext_lvl;
        logic        rdy_lvl;
        logic        hold_act;
        logic [1:0]  settle;
        logic        strap_done;
        logic [1:0]  clk_sel;
        logic        lvl_d;
        logic [1:0]  div_cnt;
        logic        clk_full;
        logic        clk_div;
        logic [1:0]  ctrl_div;
        logic [15:0] space_cfg;
        logic [3:0]  strobe_len;
        logic        err_sticky;
        logic        a_write;
        logic [1:0]  a_space;
        logic [1:0]  a_type;
        logic        a_res;
        logic [1:0]  a_be;
        logic        a_pdt;
        logic [3:0]  tcnt;
        logic        busy;
        logic        done;
        logic        err;
        logic [3:0]  ce_n;
        logic        rd_n;
        logic        oe_n;
        logic        we_n;
        logic        fifo_oe_n;
        logic [1:0]  be_n;
        logic        pdt_n;
        logic        hack_n;
        logic        breq;
        logic        drive;
        logic [31:0] rdata;
    } state_s;

    state_s     s;
    state_s     next_s;
    logic       cpu_lvl;
    logic [2:0] cpu_div;

    // Decode word-address bits 31:26 into {hit, space}
    function automatic logic [2:0] space_decode(input logic [31:0] addr);
        space_decode = {addr[31:28] == SPACE_REGION, addr[27:26]};
    endfunction

    // Pick the 4-bit configuration field of one space
    function automatic logic [3:0] space_field(input logic [15:0] cfg, input logic [1:0] sp);
        space_field = cfg[sp * SPACE_FLD_W +: SPACE_FLD_W];
    endfunction

    // CPU-derived interface clock; ratio follows the latched strap choice
    assign cpu_div = (s.clk_sel == SEL_CPU6) ? CPU_DIV6 : CPU_DIV4;

    cpu_clk_div #(
        .CNT_W (3)
    ) u_cpu_div (
        .clk_sys (clk_sys),
        .rst     (rst),
        .div_n   (cpu_div),
        .lvl     (cpu_lvl)
    );

    // Next-state logic: synchronisers, clocks, registers, access sequencer, pins
    always_comb
    begin
        logic       ifb_lvl;
        logic       tick;
        logic [2:0] dec;
        logic [3:0] fld;
        logic       act;
        logic       stb;
        logic       rd;

        next_s      = s;
        ifb_lvl     = 1'b0;
        tick        = 1'b0;
        dec         = 3'h0;
        fld         = 4'h0;
        act         = 1'b0;
        stb         = 1'b0;
        rd          = 1'b0;
        next_s.done = 1'b0;
        next_s.err  = 1'b0;
        next_s.rdata = 32'h0000_0000;

        // Pin inputs: three stages, a change counts once stages two and three agree
        next_s.ext_sync  = {s.ext_sync[1:0], ifb_ext_clk_in};
        next_s.rdy_sync  = {s.rdy_sync[1:0], async_ready_in};
        next_s.hold_sync = {s.hold_sync[1:0], ~hold_req_in_n};
        next_s.strap_a   = ifb_clk_sel_straps;
        next_s.strap_b   = s.strap_a;
        next_s.strap_c   = s.strap_b;
        if (s.ext_sync[1] == s.ext_sync[2])
        begin
            next_s.ext_lvl = s.ext_sync[2];
        end
        if (s.rdy_sync[1] == s.rdy_sync[2])
        begin
            next_s.rdy_lvl = s.rdy_sync[2];
        end
        if (s.hold_sync[1] == s.hold_sync[2])
        begin
            next_s.hold_act = s.hold_sync[2];
        end

        // Straps are taken once, after a short settle following reset release
        if (s.settle != STRAP_SETTLE)
        begin
            next_s.settle = 2'(s.settle + 2'h1);
        end
        else if (!s.strap_done && (s.strap_b == s.strap_c))
        begin
            next_s.strap_done = 1'b1;
            next_s.clk_sel    = s.strap_c;
        end

        // Interface clock level; reserved code falls back to the external clock
        if ((s.clk_sel == SEL_CPU4) || (s.clk_sel == SEL_CPU6))
        begin
            ifb_lvl = cpu_lvl;
        end
        else
        begin
            ifb_lvl = s.ext_lvl;
        end
        next_s.lvl_d    = ifb_lvl;
        tick            = ifb_lvl & ~s.lvl_d;
        next_s.clk_full = ifb_lvl;

        // Second output clock: toggling on interface edges halves, every other quarters
        if (s.ctrl_div == DIV_BY2)
        begin
            if (tick)
            begin
                next_s.clk_div = ~s.clk_div;
            end
        end
        else if (s.ctrl_div == DIV_BY4)
        begin
            if (tick)
            begin
                next_s.div_cnt = 2'(s.div_cnt + 2'h1);
                if (s.div_cnt[0])
                begin
                    next_s.clk_div = ~s.clk_div;
                end
            end
        end
        else
        begin
            next_s.clk_div = ifb_lvl;
        end

        // Register writes
        if (reg_wr)
        begin
            if (reg_addr == REG_CTRL)
            begin
                next_s.ctrl_div = reg_wdata[CTRL_DIV_LSB +: 2];
            end
            else if (reg_addr == REG_SPACE)
            begin
                next_s.space_cfg = reg_wdata[15:0];
            end
            else if (reg_addr == REG_TIMING)
            begin
                next_s.strobe_len = reg_wdata[TIM_STB_LSB +: 4];
            end
            else if ((reg_addr == REG_STATUS) && reg_wdata[STAT_ERR_BIT])
            begin
                next_s.err_sticky = 1'b0;
            end
        end

        // Register reads, data valid in the following cycle only
        if (reg_rd)
        begin
            if (reg_addr == REG_CTRL)
            begin
                next_s.rdata[CTRL_DIV_LSB +: 2] = s.ctrl_div;
            end
            else if (reg_addr == REG_SPACE)
            begin
                next_s.rdata[15:0] = s.space_cfg;
            end
            else if (reg_addr == REG_TIMING)
            begin
                next_s.rdata[TIM_STB_LSB +: 4] = s.strobe_len;
            end
            else if (reg_addr == REG_STATUS)
            begin
                next_s.rdata[STAT_SEL_LSB +: 2] = s.clk_sel;
                next_s.rdata[STAT_STRAP_BIT]    = s.strap_done;
                next_s.rdata[STAT_HOLD_BIT]     = (s.st == ST_HOLD);
                next_s.rdata[STAT_BUSY_BIT]     = s.busy;
                next_s.rdata[STAT_ERR_BIT]      = s.err_sticky;
            end
        end

        // Access sequencer; setup, strobe, wait and finish advance on interface clock edges only
        case (s.st)
            ST_IDLE:
            begin
                if (s.hold_act)
                begin
                    next_s.st = ST_HOLD;
                end
                else if (req_valid && s.strap_done)
                begin
                    dec = space_decode(req_addr);
                    fld = space_field(s.space_cfg, dec[1:0]);
                    if (!dec[2])
                    begin
                        next_s.done       = 1'b1;
                        next_s.err        = 1'b1;
                        next_s.err_sticky = 1'b1; // Set wins over a same-cycle clear
                    end
                    else
                    begin
                        next_s.st      = ST_SETUP;
                        next_s.busy    = 1'b1;
                        next_s.a_write = req_write;
                        next_s.a_space = dec[1:0];
                        next_s.a_type  = fld[SPACE_TYPE_LSB +: 2];
                        next_s.a_res   = fld[SPACE_RES_BIT];
                        next_s.a_be    = req_be;
                        next_s.a_pdt   = req_pdt;
                    end
                end
            end
            ST_SETUP:
            begin
                if (tick)
                begin
                    next_s.st   = ST_STROBE;
                    next_s.tcnt = (s.strobe_len == 4'h0) ? 4'h1 : s.strobe_len;
                end
            end
            ST_STROBE:
            begin
                if (tick)
                begin
                    if (s.tcnt > 4'h1)
                    begin
                        next_s.tcnt = 4'(s.tcnt - 4'h1);
                    end
                    else if ((s.a_type == MEM_ASYNC) && !s.rdy_lvl)
                    begin
                        next_s.st = ST_WAIT;
                    end
                    else
                    begin
                        next_s.st = ST_FINISH;
                    end
                end
            end
            ST_WAIT:
            begin
                if (tick && s.rdy_lvl)
                begin
                    next_s.st = ST_FINISH;
                end
            end
            ST_FINISH:
            begin
                if (tick)
                begin
                    next_s.st   = ST_IDLE;
                    next_s.busy = 1'b0;
                    next_s.done = 1'b1;
                end
            end
            ST_HOLD:
            begin
                if (!s.hold_act)
                begin
                    next_s.st = ST_IDLE;
                end
            end
            default:
            begin
                next_s.st = ST_IDLE;
            end
        endcase

        // Pin values follow the next state so every pin comes from a flip-flop
        act = (next_s.st == ST_SETUP) || (next_s.st == ST_STROBE)
            || (next_s.st == ST_WAIT) || (next_s.st == ST_FINISH);
        stb = (next_s.st == ST_STROBE) || (next_s.st == ST_WAIT);
        rd  = ~next_s.a_write;
        next_s.ce_n = act ? ~(4'h1 << next_s.a_space) : 4'hF;
        case (next_s.a_type)
            MEM_SDRAM:
            begin
                next_s.rd_n = ~stb;
                next_s.oe_n = ~(next_s.st == ST_SETUP);
            end
            MEM_SYNC:
            begin
                if (!next_s.a_res)
                begin
                    next_s.rd_n = ~(next_s.st == ST_SETUP);
                end
                else
                begin
                    next_s.rd_n = ~(stb & rd);
                end
                next_s.oe_n = ~(stb & rd);
            end
            default:
            begin
                next_s.rd_n = ~(stb & rd);
                next_s.oe_n = ~(stb & rd);
            end
        endcase
        next_s.we_n      = ~(stb & next_s.a_write);
        next_s.fifo_oe_n = ~(stb & rd & (next_s.a_space == 2'h3)
                           & (next_s.a_type == MEM_SYNC));
        next_s.be_n      = act ? (next_s.a_write ? ~next_s.a_be : 2'h0) : 2'h3;
        next_s.pdt_n     = ~(act & next_s.a_pdt);
        next_s.hack_n    = ~(next_s.st == ST_HOLD);
        next_s.drive     = (next_s.st != ST_HOLD);
        next_s.breq      = (next_s.st == ST_HOLD) & req_valid;
    end

    // State register; active-low pins idle high and pins drive from reset
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            s            <= '0;
            s.st         <= ST_IDLE;
            s.clk_sel    <= SEL_EXT;
            s.ctrl_div   <= CTRL_RST;
            s.space_cfg  <= SPACE_RST;
            s.strobe_len <= STROBE_RST;
            s.ce_n       <= 4'hF;
            s.rd_n       <= 1'b1;
            s.oe_n       <= 1'b1;
            s.we_n       <= 1'b1;
            s.fifo_oe_n  <= 1'b1;
            s.be_n       <= 2'h3;
            s.pdt_n      <= 1'b1;
            s.hack_n     <= 1'b1;
            s.drive      <= 1'b1;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign reg_rdata             = s.rdata;
    assign req_busy              = s.busy;
    assign req_done              = s.done;
    assign req_err               = s.err;
    assign ifb_clk_out_full      = s.clk_full;
    assign ifb_clk_out_div       = s.clk_div;
    assign chip_en_n             = s.ce_n;
    assign shared_rd_strobe_n    = s.rd_n;
    assign shared_oe_ras_pin_n   = s.oe_n;
    assign shared_write_en_pin_n = s.we_n;
    assign fifo_space3_oe_n      = s.fifo_oe_n;
    assign byte_write_en_n       = s.be_n;
    assign periph_direct_xfer_n  = s.pdt_n;
    assign hold_ack_out_n        = s.hack_n;
    assign bus_req_out           = s.breq;
    assign pin_drive_en          = s.drive;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    sequence full_cpu4_wave;
        ifb_clk_out_full[*2] ##1 !ifb_clk_out_full[*2];
    endsequence

    sequence div4_high_run;
        ifb_clk_out_div[*8] ##1 !ifb_clk_out_div;
    endsequence

    chk_strap_latched: assert property (s.strap_done |=> $stable(s.clk_sel))
        else $error("clock selection changed after it was latched");

    chk_cpu_ratio: assert property (s.clk_sel == SEL_CPU6 |-> cpu_div == CPU_DIV6)
        else $error("wrong CPU division for strap code");

    chk_full_clock_rate: assert property ((s.strap_done && s.clk_sel == SEL_CPU4
        && $rose(ifb_clk_out_full)) |-> full_cpu4_wave)
        else $error("first output clock not at CPU over four");

    chk_div_four_wave: assert property ((s.clk_sel == SEL_CPU4 && s.ctrl_div == DIV_BY4
        && $stable(s.ctrl_div) && $rose(ifb_clk_out_div)) |-> div4_high_run)
        else $error("second output clock not divided by four");

    chk_addr_strobe_sel: assert property ((s.st == ST_SETUP && s.a_type == MEM_SYNC
        && !s.a_res) |-> !shared_rd_strobe_n)
        else $error("address strobe missing in sync setup");

    chk_async_read_en: assert property ((s.st == ST_STROBE && s.a_type == MEM_ASYNC
        && !s.a_write) |-> !shared_rd_strobe_n && !shared_oe_ras_pin_n)
        else $error("async read strobes not active");

    chk_sdram_row: assert property ((s.st == ST_SETUP && s.a_type == MEM_SDRAM)
        |-> !shared_oe_ras_pin_n && shared_rd_strobe_n)
        else $error("row strobe not alone in SDRAM setup");

    chk_write_strobe: assert property (!shared_write_en_pin_n
        |-> s.a_write && !(&chip_en_n))
        else $error("write enable outside a write access");

    chk_fifo_oe_space: assert property (!fifo_space3_oe_n |-> !chip_en_n[3])
        else $error("fifo output enable without space 3");

    chk_ready_wait: assert property ((s.st == ST_WAIT && !s.rdy_lvl)
        |=> s.st == ST_WAIT)
        else $error("async access ended before ready");

    chk_byte_enables: assert property ((!shared_write_en_pin_n)
        |-> byte_write_en_n == ~s.a_be)
        else $error("byte enables do not match the write");

    chk_hold_float: assert property (!hold_ack_out_n |-> !pin_drive_en && !bus_req_out
        || !hold_ack_out_n && bus_req_out && !pin_drive_en)
        else $error("pins driven during hold");

    chk_hold_ack_time: assert property ((s.st == ST_IDLE && s.hold_act)
        |=> !hold_ack_out_n ##1 (!hold_ack_out_n || !s.hold_act))
        else $error("hold not acknowledged in time");

endmodule

// ### test/mem_host_model.sv
module mem_host_model
(
    input  wire logic       clk_sys,
    input  wire logic [3:0] chip_en_n,
    input  wire logic       want_hold,
    input  wire logic [3:0] lag,
    output logic            async_ready_in,
    output logic            hold_req_in_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt = 4'h0;
    initial
    begin
        async_ready_in = 1'b1;
        hold_req_in_n = 1'b1;
    end
    // Ready stays low for lag cycles of an access; the pull-up wins when unselected
    always @(posedge clk_sys)
    begin
        cnt <= (&chip_en_n) ? 4'h0 : cnt + 4'(cnt < lag);
        async_ready_in <= (&chip_en_n) || (cnt >= lag);
        hold_req_in_n <= ~want_hold;
    end
endmodule

// ### test/tb.sv
module tb
    import ifb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys, rst, reg_wr, reg_rd, req_valid, req_write, req_pdt, req_busy;
    logic        req_done, req_err, ifb_ext_clk_in, async_ready_in, hold_req_in_n;
    logic        ifb_clk_out_full, ifb_clk_out_div, shared_rd_strobe_n, shared_oe_ras_pin_n;
    logic        shared_write_en_pin_n, fifo_space3_oe_n, periph_direct_xfer_n, hold_ack_out_n;
    logic        bus_req_out, pin_drive_en, want_hold, w, pdt, we_s, pdt_s, err_s, pf, pd;
    logic        rd_s, oe_s, fo_s;
    logic [15:0] cfg;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, req_addr, d;
    logic [3:0]  chip_en_n, lag, ce_s;
    logic [1:0]  req_be, byte_write_en_n, ifb_clk_sel_straps, be, be_s, sp;
    int          mismatches, n_compared, n, kf, kd;

    ifb_pin_ctrl uut (.*);
    mem_host_model partner (.*);

    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // External interface clock at one eighth of the system clock
    initial
    begin
        ifb_ext_clk_in = 1'b0;
        forever
        begin
            repeat (4) @(posedge clk_sys);
            ifb_ext_clk_in <= ~ifb_ext_clk_in;
        end
    end

    // Strobes that go low in one access: {read strobe, output enable, fifo enable}
    function automatic logic [2:0] strobes(input logic [3:0] f, input logic wr,
        input logic [1:0] s);
        if (f[1:0] == MEM_SDRAM)
            return 3'h6;
        if (f[1:0] == MEM_SYNC)
            return {!f[SPACE_RES_BIT] || !wr, !wr, !wr && s == 2'h3};
        return {!wr, !wr, 1'b0};
    endfunction

    // Rising edges of both output clocks over 96 cycles
    task automatic count_edges();
        kf = 0;
        kd = 0;
        repeat (96)
        begin
            {pf, pd} = {ifb_clk_out_full, ifb_clk_out_div};
            @(negedge clk_sys);
            kf += int'(ifb_clk_out_full & !pf);
            kd += int'(ifb_clk_out_div & !pd);
        end
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // A used-up wait is a mismatch and ends the run at once
    task automatic bound(input int k, input int lim);
        if (k >= lim)
        begin
            mismatches++;
            $display("CHECK FAILED wait expected %0d seen %0d", lim - 1, k);
            complete_run();
        end
    endtask

    // One register cycle; read data are taken in the cycle after the strobe
    task automatic bus(input logic wr_op, input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= wr_op;
        reg_rd <= !wr_op;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        d = reg_rdata;
    endtask

    // One-cycle request pulse, so it cannot be taken twice; pins logged until done
    task automatic access(input logic [31:0] a);
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req_write <= w;
        req_addr <= a;
        req_be <= be;
        req_pdt <= pdt;
        @(posedge clk_sys);
        req_valid <= 1'b0;
        {ce_s, be_s, we_s, pdt_s, rd_s, oe_s, fo_s} = 11'h7E0;
        for (n = 0; n < 200 && req_done !== 1'b1; n++)
        begin
            @(negedge clk_sys);
            if (chip_en_n !== 4'hF)
                {ce_s, be_s} = {chip_en_n, byte_write_en_n};
            we_s |= !shared_write_en_pin_n;
            pdt_s |= !periph_direct_xfer_n;
            rd_s |= !shared_rd_strobe_n;
            oe_s |= !shared_oe_ras_pin_n;
            fo_s |= !fifo_space3_oe_n;
        end
        err_s = req_err;
        bound(n, 200);
    endtask

    initial
    begin
        {rst, reg_wr, reg_rd, req_valid, req_write, req_pdt, want_hold} = 7'h40;
        {reg_addr, reg_wdata, req_addr, req_be, lag} = '0;
        ifb_clk_sel_straps = 2'h1;
        mismatches = 0;
        n_compared = 0;
        void'($urandom(34));
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (10) @(posedge clk_sys);
        // Reset values, an unmapped place and the captured straps
        bus(0, REG_CTRL, 0);
        check("ctrl", d, 32'(CTRL_RST));
        bus(0, REG_TIMING, 0);
        check("timing", d, 32'(STROBE_RST));
        bus(0, 8'h10, 0);
        check("unmapped", d, 0);
        bus(0, REG_STATUS, 0);
        check("straps", d & 32'h7, {29'h0, 1'b1, SEL_CPU4});
        $display("test done: registers");
        // Rising edges in 96 cycles at CPU/4: 24 undivided, halved per divider step
        for (int c = 0; c < 3; c++)
        begin
            bus(1, REG_CTRL, c);
            repeat (8) @(negedge clk_sys);
            count_edges();
            check("clk_full", 32'(kf > 22 && kf < 26), 1);
            check("clk_div", 32'(kd >= (24 >> c) - 1 && kd <= (24 >> c) + 1), 1);
        end
        $display("test done: clocks");
        // Random accesses and memory kinds, after one read of each kind in turn
        for (int i = 0; i < 16; i++)
        begin
            {sp, be, w, pdt} = 6'($urandom);
            cfg = 16'($urandom);
            if (i < 4)
                {cfg, sp, w} = {16'h6210, 2'(i), 1'b0};
            lag <= 4'($urandom_range(6, 0));
            bus(1, REG_SPACE, 32'(cfg));
            access({4'h8, sp, 26'($urandom)});
            check("pins", 32'({ce_s, be_s, we_s, pdt_s}),
                32'({~(4'h1 << sp), w ? ~be : 2'h0, w, pdt}));
            check("strobes", 32'({rd_s, oe_s, fo_s}),
                32'(strobes(cfg[4 * sp +: 4], w, sp)));
        end
        // A word address outside the four spaces selects nothing
        access(32'h4000_0000);
        check("decode", 32'({err_s, ce_s}), 32'h1F);
        bus(0, REG_STATUS, 0);
        check("err flag", 32'(d[STAT_ERR_BIT]), 32'h1);
        $display("test done: accesses");
        // The host takes the bus; a request meanwhile only raises the bus request
        want_hold <= 1'b1;
        for (n = 0; n < 40 && hold_ack_out_n !== 1'b0; n++)
            @(negedge clk_sys);
        bound(n, 40);
        @(posedge clk_sys);
        req_valid <= 1'b1;
        repeat (4) @(negedge clk_sys);
        check("hold", 32'({pin_drive_en, bus_req_out, req_busy}),
            32'h2);
        @(posedge clk_sys);
        req_valid <= 1'b0;
        want_hold <= 1'b0;
        for (n = 0; n < 40 && pin_drive_en !== 1'b1; n++)
            @(negedge clk_sys);
        bound(n, 40);
        check("release", 32'({hold_ack_out_n, req_busy}), 32'h2);
        $display("test done: hold");
        // Mid-run resets take new straps: CPU over six, then the external clock
        for (int k = 0; k < 2; k++)
        begin
            @(posedge clk_sys);
            ifb_clk_sel_straps <= k ? SEL_EXT : SEL_CPU6;
            rst <= 1'b1;
            repeat (20) @(posedge clk_sys);
            rst <= 1'b0;
            repeat (10) @(posedge clk_sys);
            bus(0, REG_STATUS, 0);
            check("straps", d & 32'h7, {29'h0, 1'b1, k ? SEL_EXT : SEL_CPU6});
            count_edges();
            check("clk_full", 32'(kf > 14 - 4 * k && kf < 18 - 4 * k), 1);
            check("clk_div", 32'(kd > 14 - 4 * k && kd < 18 - 4 * k), 1);
        end
        $display("test done: resets");
        complete_run();
    end
endmodule
